// file: verilog/pmq_host.sv
`timescale 1ns/1ps
`include "pmq_params.svh"
// Host controller end: software registers, command issue and completion capture.
module pmq_host (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [3:0] addr_i,   // Register offset.
    input  wire logic [7:0] wdata_i,  // Write data.
    input  wire logic       wr_i,     // Write strobe.
    input  wire logic       rd_i,     // Read strobe.
    output logic      [7:0] rdata_o,  // Read data, one cycle after the strobe.
    output logic            irq_o,    // Level interrupt.
    pmq_link_if.host        link
);
    import pmq_pkg::*;

    // Whole state of the host end.
    typedef struct packed {
        logic [7:0] command;   // Command code to send.
        logic [7:0] dev_head;  // Device/head value to send.
        logic       valid;     // Issue pulse.
        logic       pending;   // Command outstanding.
        logic [7:0] result;    // Captured sector count.
        logic [7:0] status;    // Captured status.
        logic [7:0] error;     // Captured error.
        logic       irq_stat;  // Sticky completion bit.
        logic       irq_en;    // Interrupt enable.
        logic [7:0] rdata;     // Read data.
        logic       irq;       // Interrupt output.
    } pmq_host_s;

    pmq_host_s st_r;    // Registered state.
    pmq_host_s st_nxt;  // Next state.

    // Register access, issue and completion capture.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = 1'b0;
        st_nxt.rdata = 8'h00;
        // Clear first so that a completion in the same cycle wins.
        if (wr_i && addr_i == `PMQ_REG_IRQ_CLR && wdata_i[0])
            st_nxt.irq_stat = 1'b0;
        if (link.intrq) begin
            st_nxt.result   = link.sector_cnt;
            st_nxt.status   = link.status;
            st_nxt.error    = link.error;
            st_nxt.pending  = 1'b0;
            st_nxt.irq_stat = 1'b1;
        end
        if (wr_i) begin
            case (addr_i)
                `PMQ_REG_CTRL: begin
                    // Issue only when idle; writes while pending are dropped.
                    if (!st_r.pending) begin
                        st_nxt.command = wdata_i;
                        st_nxt.valid   = 1'b1;
                        st_nxt.pending = 1'b1;
                    end
                end
                // Fixed bits forced, device-select cleared, bits 6 and 3 to 0 kept as written.
                `PMQ_REG_DEVHEAD: st_nxt.dev_head = (wdata_i & 8'h4F) | 8'hA0;
                `PMQ_REG_IRQ_EN:  st_nxt.irq_en   = wdata_i[0];
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                `PMQ_REG_CTRL:     st_nxt.rdata = st_r.command;
                `PMQ_REG_DEVHEAD:  st_nxt.rdata = st_r.dev_head;
                `PMQ_REG_RESULT:   st_nxt.rdata = st_r.result;
                `PMQ_REG_STATUS:   st_nxt.rdata = st_r.status;
                `PMQ_REG_IRQ_STAT: st_nxt.rdata = {7'h00, st_r.irq_stat};
                `PMQ_REG_IRQ_EN:   st_nxt.rdata = {7'h00, st_r.irq_en};
                4'h7:              st_nxt.rdata = st_r.error;
                4'h8:              st_nxt.rdata = {7'h00, st_r.pending};
                default:           st_nxt.rdata = 8'h00;
            endcase
        end
        st_nxt.irq = st_nxt.irq_stat & st_nxt.irq_en;
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_r <= '{command: 8'h00, dev_head: `PMQ_DEVHEAD_RST, valid: 1'b0,
                      pending: 1'b0, result: 8'h00, status: `PMQ_STATUS_RST,
                      error: 8'h00, irq_stat: 1'b0, irq_en: 1'b0, rdata: 8'h00,
                      irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Link and software outputs from the register.
    assign link.command   = st_r.command;
    assign link.dev_head  = st_r.dev_head;
    assign link.cmd_valid = st_r.valid;
    assign rdata_o        = st_r.rdata;
    assign irq_o          = st_r.irq;
endmodule

// file: verilog/pmq_params.svh
`ifndef PMQ_PARAMS_SVH
`define PMQ_PARAMS_SVH

// Command codes for the power-mode query, primary and alternate.
`define PMQ_CMD_QUERY      8'hE5
`define PMQ_CMD_QUERY_ALT  8'h98
// Sector count answers.
`define PMQ_CODE_ACTIVE    8'h00
`define PMQ_CODE_LOWPOWER  8'hFF
// Device/head field positions.
`define PMQ_DH_LBA_BIT     6
`define PMQ_DH_DEV_BIT     4
// Status register bit positions.
`define PMQ_ST_BUSY        7
`define PMQ_ST_READY       6
`define PMQ_ST_FAULT       5
`define PMQ_ST_SEEK        4
`define PMQ_ST_DRQ         3
`define PMQ_ST_CORR        2
`define PMQ_ST_INDEX       1
`define PMQ_ST_ERR         0
// Error register bit position of the abort flag.
`define PMQ_ER_ABORT       2
// Host register map offsets.
`define PMQ_REG_CTRL       4'h0
`define PMQ_REG_DEVHEAD    4'h1
`define PMQ_REG_RESULT     4'h2
`define PMQ_REG_STATUS     4'h3
`define PMQ_REG_IRQ_STAT   4'h4
`define PMQ_REG_IRQ_CLR    4'h5
`define PMQ_REG_IRQ_EN     4'h6
// Reset values.
`define PMQ_DEVHEAD_RST    8'hA0
`define PMQ_STATUS_RST     8'h50
// Cycles the device spends executing a command.
`define PMQ_EXEC_CYCLES    4

`endif

// file: verilog/pmq_pkg.sv
package pmq_pkg;
    // Protocol class of a command.
    typedef enum logic [2:0] {
        PMQ_PROT_PIO_IN  = 3'h1,
        PMQ_PROT_PIO_OUT = 3'h2,
        PMQ_PROT_NODATA  = 3'h3,
        PMQ_PROT_DMA     = 3'h4,
        PMQ_PROT_VENDOR  = 3'h5
    } pmq_prot_e;
    // Power state of the drive.
    typedef enum logic [1:0] {
        PMQ_PWR_ACTIVE,
        PMQ_PWR_IDLE,
        PMQ_PWR_STANDBY,
        PMQ_PWR_SLEEP
    } pmq_pwr_e;
    typedef logic [7:0] pmq_byte_t;
endpackage

// file: verilog/pmq_link_if.sv
`timescale 1ns/1ps
// Task-file link between the host controller and the device.
interface pmq_link_if;
    logic [7:0] command;     // Command code.
    logic [7:0] dev_head;    // Device/head register.
    logic       cmd_valid;   // One-cycle pulse: command block written.
    logic [7:0] sector_cnt;  // Returned sector count.
    logic [7:0] status;      // Returned status.
    logic [7:0] error;       // Returned error.
    logic       intrq;       // One-cycle completion interrupt.
    modport host (output command, dev_head, cmd_valid,
                  input sector_cnt, status, error, intrq);
    modport dev  (input command, dev_head, cmd_valid,
                  output sector_cnt, status, error, intrq);
endinterface

// file: verilog/pmq_decode.sv
`timescale 1ns/1ps
`include "pmq_params.svh"
// Classifies a command code into query flag and protocol class.
module pmq_decode (
    input  wire logic [7:0]        code_i,
    output logic                   is_query_o,
    output pmq_pkg::pmq_prot_e     prot_o
);
    import pmq_pkg::*;

    // Alternate code is folded onto the primary one.
    always_comb begin
        is_query_o = (code_i == `PMQ_CMD_QUERY) || (code_i == `PMQ_CMD_QUERY_ALT);
        // Class by command family; the query itself carries no data.
        // Bit 0, the retry bit, never takes part in the class.
        case (code_i[7:4])
            4'h2: prot_o = code_i[3] ? PMQ_PROT_DMA : PMQ_PROT_PIO_IN;
            4'h3: prot_o = code_i[3] ? PMQ_PROT_DMA : PMQ_PROT_PIO_OUT;
            4'hC: prot_o = code_i[3] ? PMQ_PROT_DMA : PMQ_PROT_PIO_IN;
            default: prot_o = PMQ_PROT_NODATA;
        endcase
    end
endmodule

// file: verilog/pmq_device.sv
`timescale 1ns/1ps
`include "pmq_params.svh"
module pmq_device (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    pmq_link_if.dev                link,
    input  wire pmq_pkg::pmq_pwr_e power_state_i, // Present power state.
    output logic                   lba_mode_o,    // Addressing mode of last command.
    output logic                   busy_o         // Executing a command.
);
    import pmq_pkg::*;

    typedef enum logic [1:0] {PMQ_D_IDLE, PMQ_D_EXEC, PMQ_D_DONE} pmq_dstate_e;

    // Whole state of the device end.
    typedef struct packed {
        pmq_dstate_e state;     // Sequencer state.
        logic [2:0]  cnt;       // Execution counter.
        logic        is_query;  // Command latched was the query.
        logic        lba;       // Latched addressing mode.
        logic [7:0]  seccnt;    // Sector count result.
        logic [7:0]  status;    // Status result.
        logic [7:0]  error;     // Error result.
        logic        intrq;     // Completion pulse.
    } pmq_dev_s;

    pmq_dev_s   st_r;           // Registered state.
    pmq_dev_s   st_nxt;         // Next state.
    logic       dec_query;      // Decoder: code is the query.
    pmq_prot_e  dec_prot;       // Decoder: protocol class, unused here.

    // Shared command decoder.
    pmq_decode u_dec (
        .code_i     (link.command),
        .is_query_o (dec_query),
        .prot_o     (dec_prot)
    );

    // Next-state logic of the command sequencer.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.intrq = 1'b0;
        case (st_r.state)
            PMQ_D_IDLE: begin
                // The device-select bit is not examined, so it answers as device zero.
                if (link.cmd_valid) begin
                    st_nxt.is_query = dec_query;
                    st_nxt.lba      = link.dev_head[`PMQ_DH_LBA_BIT];
                    st_nxt.cnt      = 3'(`PMQ_EXEC_CYCLES - 1);
                    st_nxt.status[`PMQ_ST_BUSY] = 1'b1;
                    st_nxt.state    = PMQ_D_EXEC;
                end
            end
            PMQ_D_EXEC: begin
                if (st_r.cnt == 3'h0) begin
                    st_nxt.state = PMQ_D_DONE;
                end else begin
                    st_nxt.cnt = st_r.cnt - 3'h1;
                end
            end
            PMQ_D_DONE: begin
                // Final registers first, interrupt in the same edge they settle.
                st_nxt.status = `PMQ_STATUS_RST;
                st_nxt.error  = 8'h00;
                if (st_r.is_query) begin
                    // Standby/sleep report all ones, else zero.
                    if (power_state_i == PMQ_PWR_STANDBY || power_state_i == PMQ_PWR_SLEEP)
                        st_nxt.seccnt = `PMQ_CODE_LOWPOWER;
                    else
                        st_nxt.seccnt = `PMQ_CODE_ACTIVE;
                end else begin
                    // Unsupported command is aborted.
                    st_nxt.error[`PMQ_ER_ABORT] = 1'b1;
                    st_nxt.status[`PMQ_ST_ERR]  = 1'b1;
                end
                st_nxt.intrq = 1'b1;
                st_nxt.state = PMQ_D_IDLE;
            end
            default: st_nxt.state = PMQ_D_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_r <= '{state: PMQ_D_IDLE, cnt: 3'h0, is_query: 1'b0, lba: 1'b0,
                      seccnt: 8'h00, status: `PMQ_STATUS_RST, error: 8'h00, intrq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register.
    assign link.sector_cnt = st_r.seccnt;
    assign link.status     = st_r.status;
    assign link.error      = st_r.error;
    assign link.intrq      = st_r.intrq;
    assign lba_mode_o      = st_r.lba;
    assign busy_o          = st_r.status[`PMQ_ST_BUSY];
endmodule

// file: test/pmq_link_checker.sv
`timescale 1ns/1ps
// Watches the task-file link between the host end and the device end.
module pmq_link_checker (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] command,
    input  wire logic [7:0] dev_head,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] sector_cnt,
    input  wire logic [7:0] status,
    input  wire logic [7:0] error,
    input  wire logic       intrq
);
    // Every check uses the one clock and rests while reset is high.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_query_done: assert property (cmd_valid && (command == 8'hE5 || command == 8'h98)
        |-> ##6 intrq && status == 8'h50 && error == 8'h00) else $error("query end wrong");
    a_other_abort: assert property (cmd_valid && command != 8'hE5 && command != 8'h98
        |-> ##6 intrq && status == 8'h51 && error == 8'h04) else $error("abort end wrong");
    a_busy_span: assert property (cmd_valid |=> status[7] [*5] ##1 !status[7])
        else $error("busy span wrong");
    a_irq_pulse: assert property (intrq |=> !intrq)
        else $error("interrupt longer than one cycle");
    a_irq_cause: assert property (intrq |-> $past(cmd_valid, 6))
        else $error("interrupt without command");
    a_flags_clear: assert property (intrq |-> !status[7] && !status[5] && !status[2])
        else $error("final status flags set");
    a_dev_zero: assert property (cmd_valid |-> !dev_head[4])
        else $error("device select not zero");
    a_fixed_ones: assert property (cmd_valid |-> dev_head[7] && dev_head[5])
        else $error("fixed device bits wrong");
    a_count_hold: assert property (!intrq |-> $stable(sector_cnt))
        else $error("sector count moved");
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
// Drives the host register port and the device power state, checks results.
module tb_top;
    import pmq_pkg::*;
    // One ordinary case: power state, command code, expected sector count.
    typedef struct { pmq_pwr_e pwr; logic [7:0] code; logic [7:0] res; } pmq_row_s;
    logic       clk_i         = 1'b0;
    logic       reset_i       = 1'b1;
    logic [3:0] addr_i        = 4'h0;
    logic [7:0] wdata_i       = 8'h00;
    logic       wr_i          = 1'b0;
    logic       rd_i          = 1'b0;
    pmq_pwr_e   power_state_i = PMQ_PWR_ACTIVE;
    logic [7:0] rdata_o;
    logic       irq_o;
    logic       lba_mode_o;
    logic       busy_o;
    logic [7:0] rd_val;
    int         fail_count    = 0;
    int         total_checks  = 0;
    pmq_row_s   rows [4]      = '{'{PMQ_PWR_ACTIVE, 8'hE5, 8'h00},
                                  '{PMQ_PWR_STANDBY, 8'hE5, 8'hFF},
                                  '{PMQ_PWR_IDLE, 8'h98, 8'h00}, '{PMQ_PWR_SLEEP, 8'h98, 8'hFF}};
    pmq_link_if link ();
    pmq_host pmq_host_inst (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .link(link));
    pmq_device pmq_device_inst (.clk_i(clk_i), .reset_i(reset_i), .link(link),
        .power_state_i(power_state_i), .lba_mode_o(lba_mode_o), .busy_o(busy_o));
    pmq_link_checker pmq_link_checker_inst (.clk_i(clk_i), .reset_i(reset_i),
        .command(link.command), .dev_head(link.dev_head), .cmd_valid(link.cmd_valid),
        .sector_cnt(link.sector_cnt), .status(link.status), .error(link.error),
        .intrq(link.intrq));
    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;
    // One-cycle register write.
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // One-cycle register read; the data are taken in the following cycle.
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rd_val = rdata_o;
    endtask
    // Compares one byte-wide result and counts it.
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Issues a command and waits out the fixed completion time.
    // Only the command code is written, so no sector count option bit is ever sent.
    task automatic issue(input logic [7:0] code);
        reg_wr(4'h0, code);
        repeat (8) @(posedge clk_i);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Cuts a hang short well after the few hundred cycles the tests need.
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        reg_rd(4'h3); chk("status", 8'h50, rd_val);
        reg_rd(4'h1); chk("devhead", 8'hA0, rd_val);
        reg_rd(4'hF); chk("unmapped", 8'h00, rd_val);
        $display("reset test done");
        reg_wr(4'h6, 8'h01);
        // Ordinary cases: every power state and both query codes.
        foreach (rows[i]) begin
            @(posedge clk_i);
            power_state_i <= rows[i].pwr;
            issue(rows[i].code);
            reg_rd(4'h2); chk("result", rows[i].res, rd_val);
            reg_rd(4'h3); chk("status", 8'h50, rd_val);
            chk("irq", 8'h01, {7'h0, irq_o});
            reg_wr(4'h5, 8'h01);
            reg_rd(4'h4); chk("irq_stat", 8'h00, rd_val);
            $display("row %0d done", i);
        end
        // Unknown command with the interrupt masked: abort, count untouched.
        reg_wr(4'h6, 8'h00);
        issue(8'hEF);
        reg_rd(4'h2); chk("result", 8'hFF, rd_val);
        reg_rd(4'h3); chk("status", 8'h51, rd_val);
        reg_rd(4'h7); chk("error", 8'h04, rd_val);
        chk("irq masked", 8'h00, {7'h0, irq_o});
        reg_rd(4'h4); chk("irq_stat", 8'h01, rd_val);
        reg_wr(4'h5, 8'h01);
        $display("abort test done");
        // Device-select and fixed bits are forced; addressing mode follows bit 6.
        reg_wr(4'h1, 8'hFF);
        reg_rd(4'h1); chk("devhead", 8'hEF, rd_val);
        @(posedge clk_i);
        power_state_i <= PMQ_PWR_ACTIVE;
        issue(8'hE5);
        chk("lba", 8'h01, {7'h0, lba_mode_o});
        reg_rd(4'h7); chk("error", 8'h00, rd_val);
        reg_wr(4'h1, 8'h00);
        issue(8'h98);
        chk("lba", 8'h00, {7'h0, lba_mode_o});
        $display("device head test done");
        // A second command while one is pending is refused.
        reg_wr(4'h0, 8'hE5);
        reg_wr(4'h0, 8'hEF);
        reg_rd(4'h0); chk("command", 8'hE5, rd_val);
        chk("busy", 8'h01, {7'h0, busy_o});
        reg_rd(4'h8); chk("pending", 8'h01, rd_val);
        repeat (8) @(posedge clk_i);
        reg_rd(4'h3); chk("status", 8'h50, rd_val);
        chk("busy", 8'h00, {7'h0, busy_o});
        reg_rd(4'h8); chk("pending", 8'h00, rd_val);
        $display("back to back test done");
        // Reset in mid-command: both ends drop the command and come back idle.
        reg_wr(4'h0, 8'hE5);
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        reg_rd(4'h3); chk("status", 8'h50, rd_val);
        reg_rd(4'h8); chk("pending", 8'h00, rd_val);
        reg_rd(4'h1); chk("devhead", 8'hA0, rd_val);
        issue(8'hEF);
        reg_rd(4'h3); chk("status", 8'h51, rd_val);
        $display("mid-run reset test done");
        final_report();
    end
endmodule
